// >>> csu_top.sv
// chip-select pin unit with numerics coprocessor handshake
`timescale 1ns/10ps
module csu_top #(
  parameter bit WIDE_BUS = 1'b1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // bus cycle from core
  input wire logic cyc_start_i,
  input wire logic cyc_mem_i,
  input wire logic cyc_io_i,
  input wire logic [csu_pkg::ADDR_W-1:0] cyc_addr_i,
  input wire logic copro_access_i,
  input wire logic npx_op_start_i,
  // configuration from core-side control
  input wire logic cfg_wr_i,
  input wire logic [3:0] cfg_sel_i,
  input wire logic [csu_pkg::ADDR_W-1:0] cfg_base_i,
  input wire logic [csu_pkg::ADDR_W-1:0] cfg_limit_i,
  input wire logic mid_enable_i,
  input wire logic per_enable_i,
  input wire logic numerics_mode_i,
  input wire logic addr_out_mode_i,
  // coprocessor inputs on shared pins
  input wire logic copro_request_i,
  input wire logic copro_fault_i,
  // pins
  output logic midrange_sel0_or_copro_request_oe_n_o,
  output logic midrange_sel0_or_copro_request_o,
  output logic midrange_sel1_or_copro_fault_oe_n_o,
  output logic midrange_sel1_or_copro_fault_o,
  output logic midrange_sel2_o,
  output logic midrange_sel3_or_copro_select_o,
  output logic [csu_pkg::PER_LO_N-1:0] periph_select_low_o,
  output logic periph_select5_or_addr1_o,
  output logic periph_select6_or_addr2_o,
  // core side status
  output logic copro_req_seen_o,
  output logic fault_irq_o,
  output logic [7:0] fault_itype_o
);
  localparam int NR = csu_pkg::PER_N + csu_pkg::MID_N;

  csu_range_if rif ();

  logic [csu_pkg::ADDR_W-1:0] base_r [NR];
  logic [csu_pkg::ADDR_W-1:0] limit_r [NR];
  logic [NR-1:0] prog_r;
  logic [csu_pkg::ADDR_W-1:0] addr_r;
  logic mem_r;
  logic io_r;
  logic active_r;
  logic copro_acc_r;
  logic [1:0] lat_a_r;
  logic [csu_pkg::MID_N-1:0] mid_o_r;
  logic [csu_pkg::PER_N-1:0] per_o_r;
  logic oe0_n_r;
  logic oe1_n_r;
  logic req_r;
  logic irq_r;
  logic [7:0] itype_r;

  // pass ranges and the current address to the comparators
  assign rif.addr = addr_r;
  assign rif.base = base_r;
  assign rif.limit = limit_r;

  csu_range_dec #(.N(NR)) u_dec (
    .rif(rif)
  );

  // decoded qualify terms
  wire npx_on = numerics_mode_i && WIDE_BUS;
  wire [csu_pkg::PER_N-1:0] per_hit = rif.hit[csu_pkg::PER_N-1:0];
  wire [csu_pkg::MID_N-1:0] mid_hit = rif.hit[NR-1:csu_pkg::PER_N];
  wire [csu_pkg::PER_N-1:0] per_prog = prog_r[csu_pkg::PER_N-1:0];
  wire [csu_pkg::MID_N-1:0] mid_prog = prog_r[NR-1:csu_pkg::PER_N];
  wire [csu_pkg::MID_N-1:0] mid_act = {csu_pkg::MID_N{active_r && mem_r && mid_enable_i}}
      & mid_hit & mid_prog;
  wire [csu_pkg::PER_N-1:0] per_act = {csu_pkg::PER_N{active_r && (mem_r || io_r)
      && per_enable_i}} & per_hit & per_prog;
  wire cfg_idx_ok = cfg_sel_i < 4'(NR);
  wire fault_hit = npx_on && npx_op_start_i && copro_fault_i;

  // range storage; unprogrammed ranges keep their select idle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prog_r <= '0;
    end else if (cfg_wr_i && cfg_idx_ok) begin
      prog_r[cfg_sel_i] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (cfg_wr_i && cfg_idx_ok) begin
      base_r[cfg_sel_i] <= cfg_base_i;
      limit_r[cfg_sel_i] <= cfg_limit_i;
    end
  end

  // latch the cycle address at cycle start, held for the whole cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      addr_r <= '0;
      mem_r <= 1'b0;
      io_r <= 1'b0;
      active_r <= 1'b0;
      copro_acc_r <= 1'b0;
      lat_a_r <= 2'h0;
    end else if (cyc_start_i) begin
      addr_r <= cyc_addr_i;
      mem_r <= cyc_mem_i;
      io_r <= cyc_io_i;
      active_r <= cyc_mem_i || cyc_io_i;
      copro_acc_r <= copro_access_i;
      lat_a_r <= cyc_addr_i[2:1];
    end
  end

  // pin drivers, all registered
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mid_o_r <= {csu_pkg::MID_N{csu_pkg::SEL_IDLE}};
      per_o_r <= {csu_pkg::PER_N{csu_pkg::SEL_IDLE}};
      oe0_n_r <= 1'b0;
      oe1_n_r <= 1'b0;
    end else begin
      mid_o_r <= ~mid_act;
      per_o_r <= ~per_act;
      // pins 0 and 1 become inputs in numerics mode
      oe0_n_r <= npx_on;
      oe1_n_r <= npx_on;
      if (npx_on) begin
        mid_o_r[3] <= ~(active_r && copro_acc_r);
      end
      if (addr_out_mode_i) begin
        per_o_r[6:5] <= lat_a_r;
      end
    end
  end

  // coprocessor handshake inputs only looked at in numerics mode
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      req_r <= 1'b0;
      irq_r <= 1'b0;
      itype_r <= 8'h00;
    end else begin
      req_r <= npx_on && copro_request_i;
      irq_r <= fault_hit;
      // type code kept from the first fault on, so the core may read it late
      if (fault_hit) begin
        itype_r <= csu_pkg::FAULT_ITYPE;
      end
    end
  end

  assign midrange_sel0_or_copro_request_o = mid_o_r[0];
  assign midrange_sel0_or_copro_request_oe_n_o = oe0_n_r;
  assign midrange_sel1_or_copro_fault_o = mid_o_r[1];
  assign midrange_sel1_or_copro_fault_oe_n_o = oe1_n_r;
  assign midrange_sel2_o = mid_o_r[2];
  assign midrange_sel3_or_copro_select_o = mid_o_r[3];
  assign periph_select_low_o = per_o_r[csu_pkg::PER_LO_N-1:0];
  assign periph_select5_or_addr1_o = per_o_r[5];
  assign periph_select6_or_addr2_o = per_o_r[6];
  assign copro_req_seen_o = req_r;
  assign fault_irq_o = irq_r;
  assign fault_itype_o = itype_r;

  property p_mid_sel;
    @(posedge ref_clk_i) disable iff (rst_i)
    (mid_act[2]) |=> !midrange_sel2_o;
  endproperty
  a_mid_sel: assert property (p_mid_sel) else $error("mid select 2 missed");

  property p_npx_dir;
    @(posedge ref_clk_i) disable iff (rst_i)
    npx_on |=> midrange_sel0_or_copro_request_oe_n_o && midrange_sel1_or_copro_fault_oe_n_o;
  endproperty
  a_npx_dir: assert property (p_npx_dir) else $error("handshake pins still driven");

  property p_req;
    @(posedge ref_clk_i) disable iff (rst_i)
    !npx_on |=> !copro_req_seen_o;
  endproperty
  a_req: assert property (p_req) else $error("request seen outside numerics");

  property p_irq;
    @(posedge ref_clk_i) disable iff (rst_i)
    npx_on && npx_op_start_i && copro_fault_i |=> fault_irq_o && fault_itype_o == 8'h10;
  endproperty
  a_irq: assert property (p_irq) else $error("fault interrupt missed");

  property p_cs;
    @(posedge ref_clk_i) disable iff (rst_i)
    npx_on && active_r && copro_acc_r |=> !midrange_sel3_or_copro_select_o;
  endproperty
  a_cs: assert property (p_cs) else $error("copro select missed");

  property p_per;
    @(posedge ref_clk_i) disable iff (rst_i)
    per_act[0] |=> !periph_select_low_o[0];
  endproperty
  a_per: assert property (p_per) else $error("peripheral select missed");

  property p_per_hi;
    @(posedge ref_clk_i) disable iff (rst_i)
    !addr_out_mode_i && per_act[6] |=> !periph_select6_or_addr2_o;
  endproperty
  a_per_hi: assert property (p_per_hi) else $error("upper select missed");

  property p_addr;
    @(posedge ref_clk_i) disable iff (rst_i)
    addr_out_mode_i |=> periph_select5_or_addr1_o == $past(lat_a_r[0]);
  endproperty
  a_addr: assert property (p_addr) else $error("address bit one wrong");

  property p_idle;
    @(posedge ref_clk_i) disable iff (rst_i)
    prog_r == '0 && !addr_out_mode_i && !npx_on
      |=> periph_select_low_o == 5'h1F && midrange_sel2_o;
  endproperty
  a_idle: assert property (p_idle) else $error("select active before programming");
endmodule : csu_top

// >>> csu_pkg.sv
// package for the chip-select and coprocessor pin unit
package csu_pkg;
  localparam int ADDR_W = 20;
  localparam int MID_N = 4;
  localparam int PER_LO_N = 5;
  localparam int PER_N = 7;
  // interrupt type raised on a pending coprocessor fault
  localparam logic [7:0] FAULT_ITYPE = 8'h10;
  // select outputs idle high
  localparam logic SEL_IDLE = 1'b1;
  // bus cycle kinds
  typedef enum logic [2:0] {
    CSU_IDLE = 3'b001,
    CSU_MEM = 3'b010,
    CSU_IO = 3'b100
  } csu_cyc_e;
endpackage : csu_pkg

// >>> csu_range_if.sv
// range compare lines between top and decoder
`timescale 1ns/10ps
interface csu_range_if;
  logic [csu_pkg::ADDR_W-1:0] addr;
  logic [csu_pkg::ADDR_W-1:0] base [csu_pkg::PER_N+csu_pkg::MID_N];
  logic [csu_pkg::ADDR_W-1:0] limit [csu_pkg::PER_N+csu_pkg::MID_N];
  logic [csu_pkg::PER_N+csu_pkg::MID_N-1:0] hit;
  modport top (output addr, output base, output limit, input hit);
  modport dec (input addr, input base, input limit, output hit);
endinterface : csu_range_if

// >>> csu_range_dec.sv
// address range comparator bank
`timescale 1ns/10ps
module csu_range_dec #(
  parameter int N = 11
) (
  csu_range_if.dec rif
);
  // inclusive window test
  function automatic logic in_rng(input logic [csu_pkg::ADDR_W-1:0] a,
      input logic [csu_pkg::ADDR_W-1:0] b, input logic [csu_pkg::ADDR_W-1:0] l);
    in_rng = (a >= b) && (a <= l);
  endfunction : in_rng

  // one comparator per select
  for (genvar g = 0; g < N; g++) begin : g_cmp
    assign rif.hit[g] = in_rng(rif.addr, rif.base[g], rif.limit[g]);
  end
endmodule : csu_range_dec

// >>> csu_copro_model.sv
// coprocessor model driving the handshake inputs
`timescale 1ns/10ps
module csu_copro_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // commands from the bench
  input wire logic pend_i,
  input wire logic exc_i,
  // handshake lines
  output logic copro_request_o,
  output logic copro_fault_o
);
  // registered so the lines move just after an edge
  always_ff @(posedge ref_clk_i) begin
    copro_request_o <= !rst_i && pend_i;
    copro_fault_o <= !rst_i && exc_i;
  end
endmodule : csu_copro_model

// >>> csu_tb.sv
// self-checking bench for the chip-select pin unit
`timescale 1ns/10ps
module testbench;
  logic ref_clk_i, rst_i, st, mem, io, acc, op, wr, m_en, p_en, num, am, pend, exc, rq, ft;
  logic [19:0] adr, bs, lm;
  logic [3:0] sel;
  logic m0_oe, m0, m1_oe, m1, m2, m3, p5, p6, seen, irq;
  logic [4:0] pl;
  logic [7:0] ity;
  int fail_count, comparisons, cycles;
  wire logic [10:0] pins = {m0, m1, m2, m3, p6, p5, pl};
  csu_copro_model u_cp (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .pend_i(pend), .exc_i(exc),
    .copro_request_o(rq), .copro_fault_o(ft));
  csu_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cyc_start_i(st), .cyc_mem_i(mem),
    .cyc_io_i(io), .cyc_addr_i(adr), .copro_access_i(acc), .npx_op_start_i(op),
    .cfg_wr_i(wr), .cfg_sel_i(sel), .cfg_base_i(bs), .cfg_limit_i(lm), .mid_enable_i(m_en),
    .per_enable_i(p_en), .numerics_mode_i(num), .addr_out_mode_i(am), .copro_request_i(rq),
    .copro_fault_i(ft), .midrange_sel0_or_copro_request_oe_n_o(m0_oe),
    .midrange_sel0_or_copro_request_o(m0), .midrange_sel1_or_copro_fault_oe_n_o(m1_oe),
    .midrange_sel1_or_copro_fault_o(m1), .midrange_sel2_o(m2),
    .midrange_sel3_or_copro_select_o(m3), .periph_select_low_o(pl),
    .periph_select5_or_addr1_o(p5), .periph_select6_or_addr2_o(p6),
    .copro_req_seen_o(seen), .fault_irq_o(irq), .fault_itype_o(ity));
  // free-running clock, 10 ns period
  always #5 ref_clk_i = !ref_clk_i;
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // hang guard, far above the hundred or so cycles needed
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // select shows one edge after the start edge
  task automatic cyc(input logic k_mem, input logic k_io, input logic [19:0] a, input logic c);
    @(negedge ref_clk_i);
    {st, mem, io, adr, acc} = {1'b1, k_mem, k_io, a, c};
    @(negedge ref_clk_i);
    st = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask : cyc
  task automatic cfg(input logic [3:0] s, input logic [19:0] b, input logic [19:0] l);
    @(negedge ref_clk_i);
    {wr, sel, bs, lm} = {1'b1, s, b, l};
    @(negedge ref_clk_i);
    wr = 1'b0;
  endtask : cfg
  task automatic t_reset();
    chk("idle selects", 11'h7FF, pins);
    chk("oe_n", 11'h0, {9'h0, m0_oe, m1_oe});
    chk("status", 11'h0, {1'b0, seen, irq, ity});
    m_en = 1'b1;
    p_en = 1'b1;
    cyc(1'b1, 1'b0, 20'h10000, 1'b0);
    chk("unprogrammed", 11'h7FF, pins);
    $display("test reset done");
  endtask : t_reset
  task automatic t_mid();
    cfg(4'h9, 20'h10000, 20'h1FFFF);
    cyc(1'b1, 1'b0, 20'h1FFFF, 1'b0);
    chk("mid2 mem", 11'h6FF, pins);
    cyc(1'b0, 1'b1, 20'h10000, 1'b0);
    chk("mid2 io", 11'h7FF, pins);
    cyc(1'b1, 1'b0, 20'h20000, 1'b0);
    chk("mid2 above", 11'h7FF, pins);
    m_en = 1'b0;
    cyc(1'b1, 1'b0, 20'h1FFFF, 1'b0);
    chk("mid2 disabled", 11'h7FF, pins);
    m_en = 1'b1;
    $display("test mid done");
  endtask : t_mid
  task automatic t_per();
    cfg(4'h0, 20'h00400, 20'h004FF);
    cfg(4'h5, 20'h00600, 20'h006FF);
    cfg(4'h6, 20'h00700, 20'h007FF);
    cyc(1'b0, 1'b1, 20'h00400, 1'b0);
    chk("per0 io", 11'h7FE, pins);
    cyc(1'b1, 1'b0, 20'h00600, 1'b0);
    chk("per5 mem", 11'h7DF, pins);
    cyc(1'b0, 1'b1, 20'h00700, 1'b0);
    chk("per6 io", 11'h7BF, pins);
    am = 1'b1;
    cyc(1'b0, 1'b1, 20'h00402, 1'b0);
    chk("addr 01", 11'h7BE, pins);
    cyc(1'b0, 1'b1, 20'h00404, 1'b0);
    chk("addr 10", 11'h7DE, pins);
    am = 1'b0;
    p_en = 1'b0;
    cyc(1'b0, 1'b1, 20'h00400, 1'b0);
    chk("per0 disabled", 11'h7FF, pins);
    p_en = 1'b1;
    $display("test peripheral done");
  endtask : t_per
  task automatic t_num();
    int hits;
    cfg(4'hA, 20'h30000, 20'h3FFFF);
    num = 1'b1;
    cyc(1'b1, 1'b0, 20'h30000, 1'b0);
    chk("no mid3", 11'h1, {10'h0, m3});
    chk("oe_n", 11'h3, {9'h0, m0_oe, m1_oe});
    cyc(1'b0, 1'b1, 20'h000F8, 1'b1);
    chk("copro select", 11'h0, {10'h0, m3});
    pend = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    chk("request seen", 11'h1, {10'h0, seen});
    for (int f = 0; f < 2; f++) begin
      exc = f[0];
      repeat (3) @(negedge ref_clk_i);
      op = 1'b1;
      hits = 0;
      for (int i = 0; i < 3; i++) begin
        @(negedge ref_clk_i);
        op = 1'b0;
        hits += int'(irq === 1'b1);
      end
      chk("fault irq", 11'(f), 11'(hits));
    end
    chk("irq type", 11'h10, {3'h0, ity});
    $display("test numerics done");
  endtask : t_num
  initial begin
    {ref_clk_i, rst_i, st, mem, io, acc, op, wr} = 8'h01 << 6;
    {m_en, p_en, num, am, pend, exc} = 6'h00;
    {adr, bs, lm, sel} = 64'h0;
    repeat (16) @(negedge ref_clk_i);
    rst_i = 1'b0;
    @(negedge ref_clk_i);
    t_reset();
    t_mid();
    t_per();
    t_num();
    test_done();
  end
endmodule : testbench
